/* hw/pcg_clock_ctrl.sv */
// Clock generator control: base clock selection, PLL dividers and lock status.
//
// What this block does
// - Base clock from crystal or VCO, software selected.
// - Bus clock halves base clock; monitor uses port pin.
// - Oscillator enabled by SIM signal or stop bit.
// - PLL reference is buffered crystal clock.
// - VCO center equals L times 2^E times nominal.
// - Feedback is VCO divided by N times 2^P.
// - Phase detector pulses steer loop filter.
// - Lock detector compares feedback with reference frequency.
// - Acquisition mode reads filter bit as zero.
// - Tracking whenever not acquiring or bit set.
// - Automatic mode switches filter mode by itself.
// - Automatic filter bit read-only, follows tolerance.
// - Automatic lock bit read-only, follows tolerance.
// - Lock change requests interrupt when enabled.
// - Manual mode makes filter bit software control.
// - Manual mode: no lock status, no interrupts.
// - Refuse illegal power and source select combinations.
// - Hold base clock three edges each source.
// - L zero disables PLL; zero dividers act as one.
`timescale 1ns/1ps
module pcg_clock_ctrl
	import pcg_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SYS_RST_I,
	// Avalon-MM slave
	input  wire logic [4:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic [31:0]      AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Clock pins and mode inputs
	input  wire logic        CRYSTAL_CLOCK_I,
	input  wire logic        VCO_CLOCK_I,
	input  wire logic        MONITOR_MODE_I,
	input  wire logic        PORT_C_BIT_THREE_I,
	input  wire logic        SIM_OSCILLATOR_ENABLE_I,
	input  wire logic        OSC_RUN_IN_STOP_I,
	// Oscillator and PLL controls
	output logic             OSC_ENABLE_O,
	output logic             PLL_ENABLE_O,
	output logic [31:0]      VCO_CENTER_FREQ_O,
	output logic             PUMP_UP_O,
	output logic             PUMP_DN_O,
	output logic             FILTER_TRACK_O,
	// Generated clocks
	output logic             PLL_REFERENCE_CLOCK_O,
	output logic             VCO_FEEDBACK_CLOCK_O,
	output logic             FINAL_REFERENCE_CLOCK_O,
	output logic             BASE_CLOCK_OUT_O,
	output logic             BUS_CLOCK_O,
	// Interrupt
	output logic             IRQ_O
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Bits: 0 crystal, 1 VCO, 2 monitor mode, 3 port C pin.
	logic [3:0] pin_s1_reg;  // First stage, read only by the second.
	logic [3:0] pin_s2_reg;  // Synchronised levels.
	logic [1:0] clk_d_reg;   // Delayed clock levels for edge detection.
	logic       xtal_rise;   // Crystal rising edge pulse.
	logic       vco_rise;    // VCO rising edge pulse.

	// Two flops per pin; the clocks are far slower than CLK_I by intent.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
			clk_d_reg  <= 2'h0;
		end
		else
		begin
			pin_s1_reg <= {PORT_C_BIT_THREE_I, MONITOR_MODE_I, VCO_CLOCK_I, CRYSTAL_CLOCK_I};
			pin_s2_reg <= pin_s1_reg;
			clk_d_reg  <= pin_s2_reg[1:0];
		end
	end

	assign xtal_rise = pin_s2_reg[0] & ~clk_d_reg[0];
	assign vco_rise  = pin_s2_reg[1] & ~clk_d_reg[1];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic       pon_reg;      // PLL power on.
	logic       bcs_reg;      // Base clock select, one picks the VCO.
	logic       irqen_reg;    // Lock interrupt enable.
	logic       auto_reg;     // Automatic bandwidth mode.
	logic       track_reg;    // Filter mode, zero means acquisition.
	logic       lock_reg;     // Lock status seen by software.
	logic       lchg_reg;     // Sticky lock-change flag.
	logic [7:0] n_reg;        // Modulo divider.
	logic [1:0] p_reg;        // Prescaler exponent.
	logic [1:0] e_reg;        // VCO range exponent.
	logic [7:0] l_reg;        // Linear range factor.
	logic [3:0] r_reg;        // Reference divider.
	logic       pll_active;   // PLL powered with a usable L.
	logic       wr_take;      // Write accepted this cycle.
	logic       lock_next;    // Next lock status.
	logic       det_track;    // Detector tracking decision.
	logic       det_lock;     // Detector lock decision.
	logic [7:0] wd;           // Write data low byte.

	assign pll_active = pon_reg & (l_reg != 8'h00);
	assign wr_take    = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0];
	assign wd         = AVS_WRITEDATA_I[7:0];

	// Power and source select; each illegal combination leaves the bit alone.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			pon_reg   <= 1'b0;
			bcs_reg   <= 1'b0;
			irqen_reg <= 1'b0;
		end
		else if (wr_take && AVS_ADDRESS_I == OFS_CTRL)
		begin
			irqen_reg <= wd[BIT_IRQEN];
			// Changing both at once is refused as a whole.
			if (!(wd[BIT_PON] != pon_reg && wd[BIT_BCS] != bcs_reg))
			begin
				if (!(wd[BIT_BCS] && !pon_reg))
					bcs_reg <= wd[BIT_BCS];
				if (!(!wd[BIT_PON] && bcs_reg))
					pon_reg <= wd[BIT_PON];
			end
		end
	end

	// Divider and range settings.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			n_reg <= RST_MULT;
			p_reg <= 2'h0;
			e_reg <= 2'h0;
			l_reg <= RST_LIN;
			r_reg <= RST_RDIV;
		end
		else if (wr_take)
		begin
			case (AVS_ADDRESS_I)
				OFS_MULT:  n_reg <= wd;
				OFS_RANGE:
				begin
					p_reg <= wd[RANGE_P_LO +: 2];
					e_reg <= wd[RANGE_E_LO +: 2];
				end
				OFS_LIN:   l_reg <= wd;
				OFS_RDIV:  r_reg <= wd[3:0];
				default:   n_reg <= n_reg; // Other offsets do not touch these.
			endcase
		end
	end

	// Bandwidth mode and filter state; the detector owns it in automatic mode.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			auto_reg  <= RST_AUTO;
			track_reg <= 1'b0;
		end
		else
		begin
			if (wr_take && AVS_ADDRESS_I == OFS_BW)
				auto_reg <= wd[BIT_AUTO];
			if (auto_reg)
				track_reg <= pll_active & det_track;
			else if (wr_take && AVS_ADDRESS_I == OFS_BW)
				track_reg <= wd[BIT_TRACK];
		end
	end

	// Lock status is meaningful only in automatic mode.
	assign lock_next = auto_reg & pll_active & det_lock;

	// Lock status and its change flag; a new change beats a clear.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			lock_reg <= 1'b0;
			lchg_reg <= 1'b0;
			IRQ_O    <= 1'b0;
		end
		else
		begin
			lock_reg <= lock_next;
			if (auto_reg && irqen_reg && lock_next != lock_reg)
				lchg_reg <= 1'b1;
			else if (!auto_reg)
				lchg_reg <= 1'b0;
			else if (wr_take && AVS_ADDRESS_I == OFS_STAT && wd[BIT_LCHG])
				lchg_reg <= 1'b0;
			IRQ_O <= lchg_reg & auto_reg & irqen_reg;
		end
	end

	chk_irq_on_change: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(auto_reg && irqen_reg && lock_next != lock_reg) |=> ##1 IRQ_O)
		else $error("lock change did not raise the interrupt");
	chk_manual_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(!auto_reg ##1 !auto_reg) |-> (!lock_reg && !lchg_reg))
		else $error("manual mode shows lock or a pending interrupt");
	chk_bcs_needs_pon: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		bcs_reg |-> pon_reg)
		else $error("VCO selected while the PLL is off");
	// The pin lags the status bit by one cycle, and a tracking bit left over from
	// manual mode may still show for that cycle, so the pin is looked at one later.
	chk_auto_track: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(auto_reg && !pll_active) |=> ##1 !FILTER_TRACK_O)
		else $error("filter left acquisition without an active PLL");

	// ------------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then answer
	// ------------------------------------------------------------------
	logic [7:0] rd_byte; // Read mux result.

	// Unmapped offsets read as zero.
	always_comb
	begin
		rd_byte = 8'h00;
		case (AVS_ADDRESS_I)
			OFS_CTRL:  rd_byte = {5'h00, irqen_reg, bcs_reg, pon_reg};
			OFS_BW:    rd_byte = {5'h00, lock_reg, track_reg, auto_reg};
			OFS_MULT:  rd_byte = n_reg;
			OFS_RANGE: rd_byte = {4'h0, e_reg, p_reg};
			OFS_LIN:   rd_byte = l_reg;
			OFS_RDIV:  rd_byte = {4'h0, r_reg};
			OFS_STAT:  rd_byte = {7'h00, lchg_reg};
			default:   rd_byte = 8'h00;
		endcase
	end

	// Waitrequest drops for one cycle after a request is seen.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O    <= 32'h0000_0000;
		end
		else
		begin
			AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
			if (AVS_READ_I && AVS_WAITREQUEST_O)
				AVS_READDATA_O <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------------
	// Oscillator, reference and center frequency
	// ------------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			OSC_ENABLE_O          <= 1'b0;
			PLL_ENABLE_O          <= 1'b0;
			PLL_REFERENCE_CLOCK_O <= 1'b0;
			VCO_CENTER_FREQ_O     <= 32'h0000_0000;
		end
		else
		begin
			OSC_ENABLE_O          <= SIM_OSCILLATOR_ENABLE_I | OSC_RUN_IN_STOP_I;
			PLL_ENABLE_O          <= pll_active;
			PLL_REFERENCE_CLOCK_O <= pin_s2_reg[0];
			VCO_CENTER_FREQ_O     <= (32'(l_reg) << e_reg) * NOM_FREQ_HZ;
		end
	end

	chk_osc_enable: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		##1 OSC_ENABLE_O == ($past(SIM_OSCILLATOR_ENABLE_I) | $past(OSC_RUN_IN_STOP_I)))
		else $error("oscillator enable wrong");
	chk_ref_copy: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$rose(pin_s2_reg[0]) |=> PLL_REFERENCE_CLOCK_O)
		else $error("reference clock does not follow the crystal");
	chk_center_freq: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$stable(l_reg) && $stable(e_reg) |=>
			VCO_CENTER_FREQ_O == (32'($past(l_reg)) << $past(e_reg)) * 32'd38400)
		else $error("VCO center frequency wrong");
	chk_l_zero_off: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(l_reg == 8'h00) |=> !PLL_ENABLE_O)
		else $error("PLL enabled with zero linear factor");

	// ------------------------------------------------------------------
	// Dividers, phase and lock detection
	// ------------------------------------------------------------------
	logic        fb_tick;  // Feedback divider tick.
	logic        ref_tick; // Reference divider tick.
	logic [15:0] fb_div;   // Combined prescale and modulo divisor.

	// A zero modulo value acts as one before the prescaler scales it.
	assign fb_div = 16'((n_reg == 8'h00) ? 16'h0001 : {8'h00, n_reg}) << p_reg;

	pcg_divider #(.W(16)) u_fb_div (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.en_i      (pll_active),
		.edge_i    (vco_rise),
		.divisor_i (fb_div),
		.tick_o    (fb_tick),
		.clk_o     (VCO_FEEDBACK_CLOCK_O)
	);

	pcg_divider #(.W(4)) u_ref_div (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.en_i      (pll_active),
		.edge_i    (xtal_rise),
		.divisor_i (r_reg),
		.tick_o    (ref_tick),
		.clk_o     (FINAL_REFERENCE_CLOCK_O)
	);

	pcg_lock_detect u_lock (
		.clk_i      (CLK_I),
		.rst_i      (SYS_RST_I),
		.en_i       (pll_active),
		.ref_tick_i (ref_tick),
		.fb_tick_i  (fb_tick),
		.track_o    (det_track),
		.lock_o     (det_lock)
	);

	// Pump pulse lasts from the leading tick to the lagging one.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			PUMP_UP_O      <= 1'b0;
			PUMP_DN_O      <= 1'b0;
			FILTER_TRACK_O <= 1'b0;
		end
		else
		begin
			FILTER_TRACK_O <= track_reg;
			if (!pll_active || (ref_tick && fb_tick))
			begin
				PUMP_UP_O <= 1'b0;
				PUMP_DN_O <= 1'b0;
			end
			else if (ref_tick)
			begin
				PUMP_UP_O <= ~PUMP_DN_O;
				PUMP_DN_O <= 1'b0;
			end
			else if (fb_tick)
			begin
				PUMP_DN_O <= ~PUMP_UP_O;
				PUMP_UP_O <= 1'b0;
			end
		end
	end

	chk_pump_exclusive: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		!(PUMP_UP_O && PUMP_DN_O))
		else $error("both pump directions active");

	// ------------------------------------------------------------------
	// Base clock transition and bus clock
	// ------------------------------------------------------------------
	pcg_sw_e    sw_reg;    // Transition state.
	logic       sel_reg;   // Source in use, one is the VCO.
	logic [1:0] edge_cnt;  // Edges counted while holding.
	logic       want_vco;  // Requested source after forcing.
	logic       old_edge;  // Edge of the source in use.
	logic       new_edge;  // Edge of the incoming source.
	logic       base_d;    // Base clock one cycle ago.

	assign want_vco = bcs_reg & (l_reg != 8'h00);
	// A stopped VCO cannot be waited for, so it counts as ticking.
	assign old_edge = sel_reg ? (vco_rise | ~pll_active) : xtal_rise;
	assign new_edge = sel_reg ? xtal_rise : vco_rise;

	// Hold the output while each source gives its edges, then swap.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			sw_reg           <= ST_RUN;
			sel_reg          <= 1'b0;
			edge_cnt         <= 2'd0;
			BASE_CLOCK_OUT_O <= 1'b0;
		end
		else
		begin
			case (sw_reg)
				ST_RUN:
				begin
					edge_cnt <= 2'd0;
					if (want_vco != sel_reg)
						sw_reg <= ST_OLD;
					else if (old_edge)
						BASE_CLOCK_OUT_O <= ~BASE_CLOCK_OUT_O;
				end
				ST_OLD:
					if (old_edge)
					begin
						edge_cnt <= (edge_cnt == SWITCH_EDGES - 2'd1) ? 2'd0 : edge_cnt + 2'd1;
						if (edge_cnt == SWITCH_EDGES - 2'd1)
							sw_reg <= ST_NEW;
					end
				ST_NEW:
					if (new_edge)
					begin
						edge_cnt <= (edge_cnt == SWITCH_EDGES - 2'd1) ? 2'd0 : edge_cnt + 2'd1;
						if (edge_cnt == SWITCH_EDGES - 2'd1)
						begin
							sel_reg <= ~sel_reg;
							sw_reg  <= ST_RUN;
						end
					end
				default: sw_reg <= ST_RUN;
			endcase
		end
	end

	// Bus clock halves the base clock, or follows the port pin in monitor mode.
	always_ff @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			base_d      <= 1'b0;
			BUS_CLOCK_O <= 1'b0;
		end
		else
		begin
			base_d <= BASE_CLOCK_OUT_O;
			if (pin_s2_reg[2])
				BUS_CLOCK_O <= pin_s2_reg[3];
			else if (BASE_CLOCK_OUT_O && !base_d)
				BUS_CLOCK_O <= ~BUS_CLOCK_O;
		end
	end

	chk_base_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(sw_reg != ST_RUN) |=> $stable(BASE_CLOCK_OUT_O))
		else $error("base clock moved during a source change");
	chk_bus_half: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		(!pin_s2_reg[2] && BASE_CLOCK_OUT_O && !base_d) |=> BUS_CLOCK_O != $past(BUS_CLOCK_O))
		else $error("bus clock did not toggle on a base clock rise");

endmodule

/* hw/pcg_pkg.sv */
// Shared constants for the clock generator control block.
package pcg_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL  = 5'h00; // Power, source select, irq enable.
	localparam logic [4:0] OFS_BW    = 5'h04; // Bandwidth mode, filter and lock status.
	localparam logic [4:0] OFS_MULT  = 5'h08; // Modulo divider value.
	localparam logic [4:0] OFS_RANGE = 5'h0c; // Prescaler and range exponent.
	localparam logic [4:0] OFS_LIN   = 5'h10; // Linear range factor.
	localparam logic [4:0] OFS_RDIV  = 5'h14; // Reference divider.
	localparam logic [4:0] OFS_STAT  = 5'h18; // Sticky lock-change flag.

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_PON    = 0; // Control: PLL power on.
	localparam int BIT_BCS    = 1; // Control: base clock source select.
	localparam int BIT_IRQEN  = 2; // Control: lock interrupt enable.
	localparam int BIT_AUTO   = 0; // Bandwidth: automatic mode.
	localparam int BIT_TRACK  = 1; // Bandwidth: filter tracking select or status.
	localparam int BIT_LOCK   = 2; // Bandwidth: lock status.
	localparam int BIT_LCHG   = 0; // Status: lock changed.
	localparam int RANGE_P_LO = 0; // Range: prescaler exponent low bit.
	localparam int RANGE_E_LO = 2; // Range: VCO range exponent low bit.

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic       RST_AUTO = 1'b0;  // Manual mode after reset.
	localparam logic [7:0] RST_MULT = 8'h01; // Modulo divider value.
	localparam logic [7:0] RST_LIN  = 8'h00; // Zero keeps the PLL disabled.
	localparam logic [3:0] RST_RDIV = 4'h1;  // Reference divider value.

	// ------------------------------------------------------------------
	// Timing and frequency constants
	// ------------------------------------------------------------------
	localparam int          CLK_FREQ_HZ  = 40000000; // System clock rate.
	localparam logic [31:0] NOM_FREQ_HZ  = 32'd38400; // Nominal VCO center step.
	localparam logic [1:0]  SWITCH_EDGES = 2'd3;      // Edges held per source.
	localparam logic [7:0]  LD_WINDOW    = 8'd16;     // Reference ticks per window.
	localparam logic [7:0]  LD_TRACK_TOL = 8'd2;      // Window error for tracking.
	localparam logic [7:0]  LD_LOCK_TOL  = 8'd1;      // Window error for lock.

	// ------------------------------------------------------------------
	// Base clock transition states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN = 3'b001, // Output toggles on the selected source.
		ST_OLD = 3'b010, // Holding while the old source ticks.
		ST_NEW = 3'b100  // Holding while the new source ticks.
	} pcg_sw_e;

endpackage

/* hw/pcg_divider.sv */
// Edge-count divider producing a tick pulse and a divided clock level.
`timescale 1ns/1ps
module pcg_divider
	import pcg_pkg::*;
#(
	parameter int W = 16 // Divisor width.
)
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Control
	input  wire logic         en_i,      // Divider runs while high.
	input  wire logic         edge_i,    // One-cycle pulse per source edge.
	input  wire logic [W-1:0] divisor_i, // Edges per tick, zero acts as one.
	// Result
	output logic              tick_o,    // One-cycle pulse per divided period.
	output logic              clk_o      // Toggles on every tick.
);

	logic [W-1:0] cnt_reg;  // Edges seen in the current period.
	logic [W-1:0] div_last; // Last count of a period.

	// A zero divisor would never end a period, so it behaves as one.
	assign div_last = (divisor_i == '0) ? '0 : divisor_i - W'(1);

	// Count source edges and emit a tick at the end of each period.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
			clk_o   <= 1'b0;
		end
		else if (!en_i)
		begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end
		else if (edge_i && cnt_reg >= div_last)
		begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
			clk_o   <= ~clk_o;
		end
		else
		begin
			cnt_reg <= edge_i ? cnt_reg + W'(1) : cnt_reg;
			tick_o  <= 1'b0;
		end
	end

endmodule

/* hw/pcg_lock_detect.sv */
// Frequency lock detector comparing feedback ticks against reference ticks.
`timescale 1ns/1ps
module pcg_lock_detect
	import pcg_pkg::*;
#(
	parameter logic [7:0] WINDOW    = LD_WINDOW,    // Reference ticks per window.
	parameter logic [7:0] TRACK_TOL = LD_TRACK_TOL, // Tolerance for tracking.
	parameter logic [7:0] LOCK_TOL  = LD_LOCK_TOL   // Tolerance for lock.
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Inputs
	input  wire logic en_i,       // Detector runs while the PLL is active.
	input  wire logic ref_tick_i, // Divided reference tick.
	input  wire logic fb_tick_i,  // Divided feedback tick.
	// Decisions
	output logic      track_o,    // Frequency close enough for tracking.
	output logic      lock_o      // Frequency locked.
);

	logic [7:0] ref_cnt_reg; // Reference ticks in this window.
	logic [7:0] fb_cnt_reg;  // Feedback ticks in this window.
	logic [7:0] fb_total;    // Feedback count including this cycle.
	logic [7:0] err;         // Absolute frequency error of the window.

	assign fb_total = (fb_tick_i && fb_cnt_reg != 8'hff) ? fb_cnt_reg + 8'h01 : fb_cnt_reg;
	assign err      = (fb_total > WINDOW) ? fb_total - WINDOW : WINDOW - fb_total;

	// Each window ends on a reference tick and decides mode and lock at once.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ref_cnt_reg <= 8'h00;
			fb_cnt_reg  <= 8'h00;
			track_o     <= 1'b0;
			lock_o      <= 1'b0;
		end
		else if (!en_i)
		begin
			ref_cnt_reg <= 8'h00;
			fb_cnt_reg  <= 8'h00;
			track_o     <= 1'b0;
			lock_o      <= 1'b0;
		end
		else if (ref_tick_i && ref_cnt_reg == WINDOW - 8'h01)
		begin
			ref_cnt_reg <= 8'h00;
			fb_cnt_reg  <= 8'h00;
			track_o     <= (err <= TRACK_TOL);
			lock_o      <= (err <= LOCK_TOL);
		end
		else
		begin
			ref_cnt_reg <= ref_tick_i ? ref_cnt_reg + 8'h01 : ref_cnt_reg;
			fb_cnt_reg  <= fb_total;
		end
	end

endmodule

/* tb/pcg_clk_src.sv */
// Free-running clock source standing in for the crystal or the VCO.
`timescale 1ns/1ps
module pcg_clk_src #(
	parameter realtime HALF = 100.0 // Half period in ns.
)
(
	// Control and clock
	input  wire logic en_i,  // Source runs while high.
	output logic      clk_o  // Clock; stands low while stopped.
);
	// A stopped oscillator stands low rather than holding its last level.
	initial clk_o = 1'b0;
	always #(HALF) clk_o = en_i ? ~clk_o : 1'b0;
endmodule

/* tb/pcg_clock_ctrl_test.sv */
// Self-checking bench for the clock generator control block.
`timescale 1ns/1ps
module pcg_clock_ctrl_test;
	import pcg_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, mon = 1'b0, pc3 = 1'b0;
	logic        sim = 1'b0, ois = 1'b0, xtal, vco, wq, osc, pen, up, dn, trk;
	logic        rclk, fb, fr, base, bus_clk, irq;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wd = 32'h0, rdat, q, vcf;
	logic [7:0]  l;
	logic [1:0]  e;
	int          fail_count = 0, n_compared = 0, cyc = 0, nb = 0, nu = 0, nf = 0, nr = 0;
	logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	logic [7:0]  cw [6] = '{8'h02, 8'h01, 8'h02, 8'h03, 8'h02, 8'h01};
	logic [7:0]  cr [6] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h03, 8'h01};

	// Crystal runs free; the VCO only runs while the PLL is enabled.
	pcg_clk_src #(.HALF(100.0)) xsrc (.en_i(1'b1), .clk_o(xtal));
	pcg_clk_src #(.HALF(75.0)) vsrc (.en_i(pen), .clk_o(vco));
	pcg_clock_ctrl dut (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq), .CRYSTAL_CLOCK_I(xtal),
		.VCO_CLOCK_I(vco), .MONITOR_MODE_I(mon), .PORT_C_BIT_THREE_I(pc3),
		.SIM_OSCILLATOR_ENABLE_I(sim), .OSC_RUN_IN_STOP_I(ois), .OSC_ENABLE_O(osc),
		.PLL_ENABLE_O(pen), .VCO_CENTER_FREQ_O(vcf), .PUMP_UP_O(up), .PUMP_DN_O(dn),
		.FILTER_TRACK_O(trk), .PLL_REFERENCE_CLOCK_O(rclk), .VCO_FEEDBACK_CLOCK_O(fb),
		.FINAL_REFERENCE_CLOCK_O(fr), .BASE_CLOCK_OUT_O(base), .BUS_CLOCK_O(bus_clk),
		.IRQ_O(irq));

	// 40 MHz clock, toggle counters and the hang limit.
	always #12.5 clk = ~clk;
	always @(base) nb++;
	always @(bus_clk) nu++;
	always @(fb) nf++;
	always @(fr) nr++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("compared=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd <= ~w;
		wr <= w;
		wd <= {24'h0, d};
		do @(posedge clk); while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Counts base and bus toggles over a window and checks both ranges.
	task automatic rate(input int cycles, input int exp_nb);
		nb = 0;
		nu = 0;
		repeat (cycles) @(posedge clk);
		chk({31'h0, nb >= exp_nb - 1 && nb <= exp_nb + 1}, 32'h1);
		chk({31'h0, nu >= exp_nb / 2 - 1 && nu <= exp_nb / 2 + 1}, 32'h1);
	endtask

	initial
	begin
		void'($urandom(32'h20a0));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, 5'(i * 4), 8'h00);
			chk(q, {24'h0, rv[i]});
		end
		bus(1'b1, OFS_BW, 8'h00);
		l = 8'($urandom_range(1, 255));
		e = 2'($urandom_range(0, 2));
		bus(1'b1, OFS_LIN, l);
		bus(1'b1, OFS_RANGE, {4'h0, e, 2'($urandom_range(0, 3))});
		bus(1'b1, OFS_MULT, 8'($urandom_range(1, 4)));
		@(negedge clk);
		chk(vcf, ({24'h0, l} << e) * 32'd38400);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b1, OFS_CTRL, cw[i]);
			bus(1'b0, OFS_CTRL, 8'h00);
			chk(q, {24'h0, cr[i]});
		end
		@(negedge clk);
		chk({31'h0, pen}, 32'h1);
		// The select writes above start two source swaps; let them run out.
		repeat (120) @(posedge clk);
		rate(320, 40);
		bus(1'b1, OFS_BW, 8'h02);
		repeat (40) @(posedge clk);
		bus(1'b1, OFS_CTRL, 8'h03);
		repeat (60) @(posedge clk);
		rate(240, 40);
		bus(1'b1, OFS_CTRL, 8'h01);
		bus(1'b1, OFS_LIN, 8'h00);
		repeat (2) @(negedge clk);
		chk({31'h0, pen}, 32'h0);
		bus(1'b1, OFS_BW, 8'h02);
		bus(1'b0, OFS_BW, 8'h00);
		chk(q, 32'h2);
		repeat (2) @(negedge clk);
		chk({30'h0, trk, irq}, 32'h2);
		// Automatic mode: the VCO runs at 4/3 of the crystal, so N=4 and R=3 match.
		bus(1'b1, OFS_BW, 8'h01);
		bus(1'b1, OFS_MULT, 8'h04);
		bus(1'b1, OFS_RANGE, 8'h00);
		bus(1'b1, OFS_RDIV, 8'h03);
		bus(1'b1, OFS_CTRL, 8'h05);
		bus(1'b1, OFS_LIN, 8'($urandom_range(1, 255)));
		repeat (1200) @(posedge clk);
		bus(1'b0, OFS_BW, 8'h00);
		chk(q, 32'h7);
		@(negedge clk);
		chk({30'h0, trk, irq}, 32'h3);
		bus(1'b1, OFS_CTRL, 8'h07);
		bus(1'b1, OFS_STAT, 8'h01);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		nf = 0;
		nr = 0;
		repeat (480) @(posedge clk);
		chk({31'h0, nf >= 19 && nf <= 21}, 32'h1);
		chk({31'h0, nr >= 19 && nr <= 21}, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			sim <= 1'($urandom);
			ois <= 1'($urandom);
			@(posedge clk);
			@(negedge clk);
			chk({31'h0, osc}, {31'h0, sim | ois});
		end
		@(posedge clk);
		mon <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			pc3 <= 1'(i);
			repeat (8) @(negedge clk);
			chk({31'h0, bus_clk}, {31'h0, pc3});
		end
		print_verdict();
	end
endmodule
